// ==== pkg/pma_pkg.sv ====
// Constants for the program memory addressing block.
// Assumes a single core clock and a synchronous active-high reset.
package pma_pkg;
  localparam int          PC_WIDTH    = 13;
  localparam int          WORD_WIDTH  = 14;
  localparam int          IMPL_AWIDTH = 12;
  localparam int          IMPL_DEPTH  = 4096;
  localparam logic [12:0] RESET_VEC   = 13'h0000;
  localparam logic [12:0] INTR_VEC    = 13'h0004;
  localparam logic [13:0] WORD_RESET  = 14'h0000;
  localparam logic [7:0]  DATA_RESET  = 8'h00;
endpackage

// ==== core/pma_prog_store.sv ====
// Program word store with a registered read port and a load port.
// Assumes the caller already folds the address onto the implemented range.
`timescale 1ns/10ps
module pma_prog_store
  import pma_pkg::*;
#(
  parameter int AW = IMPL_AWIDTH,
  parameter int DW = WORD_WIDTH
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Read port.
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o,
  // Load port.
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_r;
  logic [DW-1:0] rd_data_nxt;

  always_comb begin
    rd_data_nxt = mem[rd_addr_i];
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= WORD_RESET;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
endmodule

// ==== core/pma_core.sv ====
// Program counter and program memory addressing for a small 8-bit core.
// Assumes the core sequencer drives step, jump and interrupt requests in sync with REF_CLK_I.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] Instruction fetch and data access use separate buses and may both act in the same cycle.
// [R2] The program counter is 13 bits wide and addresses 8K words of 14 bits.
// [R3] Only the lower 4K words of program space exist as storage.
// [R4] An address above the implemented range wraps onto the storage instead of faulting.
// [R5] Any reset loads the program counter with 0000h.
// [R6] Taking an interrupt loads the program counter with 0004h.
// [R7] Wrap is done by dropping the top program counter bit, so N and N plus 4096 read the same word.
module pma_core
  import pma_pkg::*;
#(
  parameter int PCW   = PC_WIDTH,
  parameter int DEPTH = IMPL_DEPTH
) (
  // Clock and reset.
  input  wire logic                 REF_CLK_I,
  input  wire logic                 RST_I,
  // Sequencing requests, priority interrupt, then jump, then step.
  input  wire logic                 STEP_I,
  input  wire logic                 JUMP_I,
  input  wire logic [PCW-1:0]       JUMP_ADDR_I,
  input  wire logic                 INTR_TAKE_I,
  // Program store load port.
  input  wire logic                 LOAD_EN_I,
  input  wire logic [PCW-1:0]       LOAD_ADDR_I,
  input  wire logic [WORD_WIDTH-1:0] LOAD_DATA_I,
  // Data bus, independent of the fetch path.
  input  wire logic                 DATA_WR_I,
  input  wire logic [7:0]           DATA_WDATA_I,
  // Fetch outputs.
  output logic      [PCW-1:0]       PC_O,
  output logic      [WORD_WIDTH-1:0] INSTR_O,
  output logic                      INSTR_VALID_O,
  // Data bus output.
  output logic      [7:0]           DATA_Q_O
);
  localparam int SAW = $clog2(DEPTH);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (PCW != PC_WIDTH || DEPTH != IMPL_DEPTH) begin : g_bad_param
    $error("pma_core supports only a 13-bit counter over 4096 words");
  end

  // ****************************************************************
  // Program counter
  // ****************************************************************
  logic [PCW-1:0] pc_r;
  logic [PCW-1:0] pc_nxt;
  logic           valid_r;
  logic           valid_nxt;

  always_comb begin
    pc_nxt    = pc_r;
    valid_nxt = 1'b1;
    if (INTR_TAKE_I) begin
      pc_nxt    = INTR_VEC; // R6
      valid_nxt = 1'b0;
    end else if (JUMP_I) begin
      pc_nxt    = JUMP_ADDR_I; // R2
      valid_nxt = 1'b0;
    end else if (STEP_I) begin
      // The full 13-bit counter rolls over from 1FFFh to 0000h.
      pc_nxt = PCW'(pc_r + 1'b1); // R2
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      pc_r    <= RESET_VEC; // R5
      valid_r <= 1'b0;
    end else begin
      pc_r    <= pc_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ****************************************************************
  // Storage addressing and fetch
  // ****************************************************************
  // The top counter bit is simply not wired, so high addresses alias low ones.
  logic [SAW-1:0] fetch_addr;
  logic [SAW-1:0] load_addr;
  assign fetch_addr = pc_nxt[SAW-1:0]; // R7 R4
  assign load_addr  = LOAD_ADDR_I[SAW-1:0]; // R7

  pma_prog_store #(
    .AW (SAW),
    .DW (WORD_WIDTH)
  ) u_store (
    .clk_i     (REF_CLK_I),
    .rst_i     (RST_I),
    .rd_addr_i (fetch_addr), // R3
    .rd_data_o (INSTR_O),
    .wr_en_i   (LOAD_EN_I),
    .wr_addr_i (load_addr),
    .wr_data_i (LOAD_DATA_I)
  );

  assign PC_O          = pc_r;
  assign INSTR_VALID_O = valid_r;

  // ****************************************************************
  // Data path
  // ****************************************************************
  // Kept apart from the fetch so both may act in one cycle without arbitration.
  logic [7:0] data_r;
  logic [7:0] data_nxt;

  always_comb begin
    data_nxt = DATA_WR_I ? DATA_WDATA_I : data_r; // R1
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      data_r <= DATA_RESET;
    end else begin
      data_r <= data_nxt;
    end
  end

  assign DATA_Q_O = data_r;
endmodule

// ==== verification/pma_core_properties.sv ====
// Checker on the ports of pma_core.
// Assumes it is bound from the bench top onto the single core clock.
`timescale 1ns/10ps
module pma_core_properties (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        STEP_I,
  input wire logic        JUMP_I,
  input wire logic [12:0] JUMP_ADDR_I,
  input wire logic        INTR_TAKE_I,
  input wire logic        DATA_WR_I,
  input wire logic [7:0]  DATA_WDATA_I,
  input wire logic [12:0] PC_O,
  input wire logic        INSTR_VALID_O,
  input wire logic [7:0]  DATA_Q_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  rst_vector_a: assert property ($fell(RST_I) |-> PC_O == 13'h0000 && !INSTR_VALID_O) else $error("bad reset pc");
  intr_vector_a: assert property (INTR_TAKE_I |=> PC_O == 13'h0004 && !INSTR_VALID_O) else $error("bad intr pc");
  jump_load_a: assert property (JUMP_I && !INTR_TAKE_I |=> PC_O == $past(JUMP_ADDR_I)) else $error("bad jump");
  step_inc_a: assert property (STEP_I && !JUMP_I && !INTR_TAKE_I |=> PC_O == $past(PC_O) + 13'h1 && INSTR_VALID_O)
    else $error("bad step");
  pc_hold_a: assert property (!STEP_I && !JUMP_I && !INTR_TAKE_I |=> $stable(PC_O)) else $error("pc moved");
  data_latch_a: assert property (DATA_WR_I |=> DATA_Q_O == $past(DATA_WDATA_I)) else $error("bad data");
  data_hold_a: assert property (!DATA_WR_I |=> $stable(DATA_Q_O)) else $error("data moved");
  intr_c: cover property (INTR_TAKE_I && JUMP_I);
  wrap_c: cover property (JUMP_I && JUMP_ADDR_I[12]);
  data_c: cover property (DATA_WR_I && STEP_I);
endmodule

// ==== verification/pma_core_tb_top.sv ====
// Self-checking bench for pma_core.
// Assumes the store words are loaded through the load port before fetching.
`timescale 1ns/10ps
module pma_core_tb_top;
  import pma_pkg::*;
  logic        clk = 0, rst = 1, st = 0, jp = 0, it = 0, le = 0, dw = 0, vl;
  logic [12:0] ja = '0, la = '0, pc;
  logic [13:0] ld = '0, ins;
  logic [7:0]  dd = '0, dq;
  int          error_cnt = 0, checks = 0;
  pma_core dut (.REF_CLK_I(clk), .RST_I(rst), .STEP_I(st), .JUMP_I(jp), .JUMP_ADDR_I(ja), .INTR_TAKE_I(it),
    .LOAD_EN_I(le), .LOAD_ADDR_I(la), .LOAD_DATA_I(ld), .DATA_WR_I(dw), .DATA_WDATA_I(dd), .PC_O(pc),
    .INSTR_O(ins), .INSTR_VALID_O(vl), .DATA_Q_O(dq));
  initial forever #4 clk = ~clk;
  // Each stored word differs from its neighbours, so an aliasing slip shows up.
  function automatic logic [13:0] wd(logic [11:0] a);
    return 14'h2a00 ^ a;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(logic s, logic j, logic [12:0] a, logic i, logic w);
    @(posedge clk);
    {st, jp, ja, it, dw, dd} <= {s, j, a, i, w, 8'h5c};
    @(posedge clk);
    {st, jp, it, dw} <= 4'h0;
    #1;
  endtask
  task automatic load(logic [12:0] a);
    @(posedge clk);
    {le, la, ld} <= {1'b1, a, wd(a[11:0])};
    @(posedge clk);
    le <= 1'b0;
  endtask
  task automatic t_step_data;
    cyc(1, 0, 13'h0, 0, 1);
    chk(pc, 13'h0001);
    chk(ins, wd(1));
    chk(dq, 8'h5c);
  endtask
  task automatic t_intr;
    cyc(1, 1, 13'h0100, 1, 0);
    chk(pc, INTR_VEC);
    chk(ins, wd(4));
    chk(vl, 1'b0);
  endtask
  task automatic t_wrap;
    cyc(0, 1, 13'h1005, 0, 0);
    chk(pc, 13'h1005);
    chk(ins, wd(5));
    cyc(0, 1, 13'h0fff, 0, 0);
    cyc(1, 0, 13'h0, 0, 0);
    chk(pc, 13'h1000);
    chk(ins, wd(0));
    // Word 6 was only ever loaded through an address with the top bit set.
    cyc(0, 1, 13'h0006, 0, 0);
    chk(ins, wd(6));
  endtask
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    chk(pc, RESET_VEC);
    chk(vl, 1'b0);
    chk(ins, WORD_RESET);
    chk(dq, DATA_RESET);
    @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) load(13'(k));
    load(13'h0fff);
    load(13'h1006);
    t_step_data();
    t_intr();
    t_wrap();
    final_report();
  end
endmodule
bind pma_core pma_core_properties u_chk (.REF_CLK_I, .RST_I, .STEP_I, .JUMP_I, .JUMP_ADDR_I, .INTR_TAKE_I,
  .DATA_WR_I, .DATA_WDATA_I, .PC_O, .INSTR_VALID_O, .DATA_Q_O);
